// file: src/moc_pkg.sv
// shared constants for the meter output control block
package moc_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LOW = 8'h04;
  localparam logic [7:0] A_HIGH = 8'h08;
  localparam logic [7:0] A_OFFS = 8'h0C;
  localparam logic [7:0] A_CLAMP = 8'h10;
  localparam logic [7:0] A_SWING = 8'h14;
  localparam logic [7:0] A_TIME = 8'h18;
  localparam logic [7:0] A_BUSSP = 8'h1C;
  localparam logic [7:0] A_PIN = 8'h20;
  localparam logic [7:0] A_UPIN = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_LIVE = 8'h2C;
  // register field positions
  localparam int F_MODE = 0;
  localparam int F_FBEEP = 2;
  localparam int F_RBEEP = 3;
  localparam int F_INV = 7;
  localparam int F_DSRC = 8;
  localparam int F_RSRC = 9;
  localparam int F_OSRC = 13;
  localparam int F_FOVR = 14;
  localparam int F_UNLK = 16;
  localparam int F_SMTH = 20;
  localparam int F_HIEXT = 16;
  localparam int F_BTO = 8;
  // reset values
  localparam logic [22:0] CTRL_RST = 23'h000000;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'h0064;
  localparam logic [15:0] SWING_RST = 16'h000A;
  localparam logic [15:0] PIN_RST = 16'h0000;
  // limits of settings
  localparam logic [2:0] SMTH_MAX = 3'h5;
  localparam logic [7:0] OFFS_MAX = 8'h63;
  localparam logic [9:0] LOEXT_MAX = 10'h3E7;
  localparam logic [9:0] HIEXT_MAX = 10'h0C7;
  localparam logic [7:0] KEEP_MAX = 8'hC7;
  localparam logic [7:0] BTO_MAX = 8'h63;
  localparam logic [9:0] PERMILLE = 10'h3E8;
  // currents in 1/256 mA
  localparam logic [12:0] I_4MA = 13'h0400;
  localparam logic [12:0] I_16MA = 13'h1000;
  localparam logic [12:0] I_20MA = 13'h1400;
  localparam logic [12:0] I_24MA = 13'h1800;
  localparam logic [12:0] I_22P1 = 13'h161A;
  localparam logic [12:0] I_3P4 = 13'h0366;
  // timing
  localparam int CLK_KHZ = 25000;
  localparam int TENTH_MS = 100;
  localparam int SEC_MS = 1000;
  localparam int TENTH_CYC = TENTH_MS * CLK_KHZ;
  localparam int SEC_CYC = SEC_MS * CLK_KHZ;
  // modes
  typedef enum logic [1:0] {OM_OFF, OM_0_20, OM_4_20, OM_BUS} moc_omode_e;
  typedef enum logic [1:0] {FO_KEEP, FO_22P1, FO_3P4, FO_ZERO} moc_fovr_e;
endpackage

// file: src/moc_top.sv
// meter output control: value selection, current setpoint, beeper, passcode
`timescale 1ns/100ps

module moc_top #(
  parameter int TENTH_CYC = moc_pkg::TENTH_CYC,
  parameter int SEC_CYC = moc_pkg::SEC_CYC,
  parameter logic [15:0] RECOVERY_CODE = 16'h7316 // arbitrary value
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement front end
  input wire logic meas_valid,
  input wire logic signed [15:0] meas_value,
  input wire logic meas_over,
  input wire logic [3:0] relay_active,
  input wire logic bus_frame,
  // front panel pins
  input wire logic button_any,
  input wire logic button_esc,
  // outputs
  output logic [12:0] loop_setpoint,
  output logic loop_enable,
  output logic beeper,
  output logic critical,
  output logic signed [15:0] display_value,
  output logic [63:0] relay_value,
  output logic [3:0] relay_edit_ok
);
  typedef enum logic [1:0] {S_IDLE, S_DIV, S_DONE} moc_st_e;

  logic [22:0] ctrl_reg;
  logic signed [15:0] low_reg, high_reg, swing_reg, live_reg, ext_reg, capt_reg, w_reg;
  logic signed [7:0] offs_reg;
  logic [9:0] loext_reg, hiext_reg;
  logic [7:0] keep_reg, bto_reg, hold_cnt_reg, gap_reg;
  logic [12:0] bussp_reg, calc_reg;
  logic [15:0] upin_reg;
  logic unlocked_reg, rec_used_reg, held_reg, tracking_reg;
  logic [1:0] btn_sync_reg, esc_sync_reg;
  logic btn_prev_reg, esc_prev_reg;
  logic [3:0] relay_prev_reg;
  logic crit_prev_reg, upd1_reg, upd2_reg, upd3_reg, neg_reg;
  logic signed [23:0] acc_reg;
  logic [31:0] tenth_cnt_reg, sec_cnt_reg, quo_reg, rem_reg, den_reg;
  logic [5:0] step_reg;
  moc_st_e st_reg;

  logic setup, wr, hit;
  logic press, esc_press, tick_tenth, tick_sec, timed_out, crit_meas;
  logic [1:0] mode, fovr;
  logic signed [15:0] peak_val, out_src_val;
  logic signed [16:0] diff_w, diff_h;
  logic [32:0] trial;
  logic [12:0] imin, imax, span;
  logic signed [15:0] raw_i;
  logic [13:0] q_sat;
  logic [20:0] lo_prod, hi_prod;

  assign mode = ctrl_reg[moc_pkg::F_MODE +: 2];
  assign fovr = ctrl_reg[moc_pkg::F_FOVR +: 2];
  assign setup = psel & ~penable & ~pready;
  assign wr = psel & penable & pready & pwrite;

  // apb: no wait state, read data comes from a flop loaded during setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite)
      begin
        case (paddr)
          moc_pkg::A_CTRL: prdata <= {9'h000, ctrl_reg};
          moc_pkg::A_LOW: prdata <= {{16{low_reg[15]}}, low_reg};
          moc_pkg::A_HIGH: prdata <= {{16{high_reg[15]}}, high_reg};
          moc_pkg::A_OFFS: prdata <= {{24{offs_reg[7]}}, offs_reg};
          moc_pkg::A_CLAMP: prdata <= {6'h00, hiext_reg, 6'h00, loext_reg};
          moc_pkg::A_SWING: prdata <= {16'h0000, swing_reg};
          moc_pkg::A_TIME: prdata <= {16'h0000, bto_reg, keep_reg};
          moc_pkg::A_BUSSP: prdata <= {19'h00000, bussp_reg};
          moc_pkg::A_PIN: prdata <= {30'h00000000, rec_used_reg, unlocked_reg};
          moc_pkg::A_UPIN: prdata <= unlocked_reg ? {16'h0000, upin_reg} : 32'h00000000;
          moc_pkg::A_STAT: prdata <= {13'h0000, held_reg, beeper, critical, 3'h0, loop_setpoint};
          moc_pkg::A_LIVE: prdata <= {{16{live_reg[15]}}, live_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // address decode, unmapped answers with pslverr
  always_comb
  begin
    case (paddr)
      moc_pkg::A_CTRL, moc_pkg::A_LOW, moc_pkg::A_HIGH, moc_pkg::A_OFFS,
      moc_pkg::A_CLAMP, moc_pkg::A_SWING, moc_pkg::A_TIME, moc_pkg::A_BUSSP,
      moc_pkg::A_PIN, moc_pkg::A_UPIN, moc_pkg::A_STAT, moc_pkg::A_LIVE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // settings, saturated to their legal ranges on write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= moc_pkg::CTRL_RST;
      low_reg <= moc_pkg::LOW_RST;
      high_reg <= moc_pkg::HIGH_RST;
      offs_reg <= 8'h00;
      loext_reg <= 10'h000;
      hiext_reg <= 10'h000;
      swing_reg <= moc_pkg::SWING_RST;
      keep_reg <= 8'h00;
      bto_reg <= 8'h00;
      bussp_reg <= 13'h0000;
    end
    else if (wr)
    begin
      case (paddr)
        moc_pkg::A_CTRL:
        begin
          ctrl_reg <= pwdata[22:0];
          if (pwdata[22:20] > moc_pkg::SMTH_MAX)
            ctrl_reg[moc_pkg::F_SMTH +: 3] <= moc_pkg::SMTH_MAX;
        end
        moc_pkg::A_LOW: low_reg <= pwdata[15:0];
        moc_pkg::A_HIGH: high_reg <= pwdata[15:0];
        moc_pkg::A_OFFS:
        begin
          if ($signed(pwdata[15:0]) > $signed({8'h00, moc_pkg::OFFS_MAX}))
            offs_reg <= moc_pkg::OFFS_MAX;
          else if ($signed(pwdata[15:0]) < -$signed({8'h00, moc_pkg::OFFS_MAX}))
            offs_reg <= -moc_pkg::OFFS_MAX;
          else
            offs_reg <= pwdata[7:0];
        end
        moc_pkg::A_CLAMP:
        begin
          loext_reg <= (pwdata[9:0] > moc_pkg::LOEXT_MAX) ? moc_pkg::LOEXT_MAX : pwdata[9:0];
          hiext_reg <= (pwdata[25:16] > moc_pkg::HIEXT_MAX) ? moc_pkg::HIEXT_MAX
                       : pwdata[25:16];
        end
        moc_pkg::A_SWING: swing_reg <= pwdata[15] ? 16'h0000 : pwdata[15:0];
        moc_pkg::A_TIME:
        begin
          keep_reg <= (pwdata[7:0] > moc_pkg::KEEP_MAX) ? moc_pkg::KEEP_MAX : pwdata[7:0];
          bto_reg <= (pwdata[15:8] > moc_pkg::BTO_MAX) ? moc_pkg::BTO_MAX : pwdata[15:8];
        end
        moc_pkg::A_BUSSP: bussp_reg <= (pwdata[12:0] > moc_pkg::I_24MA) ? moc_pkg::I_24MA
                                       : pwdata[12:0];
        default: ;
      endcase
    end
  end

  // passcode: a wrong try relocks, recovery code only once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upin_reg <= moc_pkg::PIN_RST;
      unlocked_reg <= 1'b0;
      rec_used_reg <= 1'b0;
    end
    else
    begin
      if (wr && paddr == moc_pkg::A_PIN)
      begin
        if (!rec_used_reg && pwdata[15:0] == RECOVERY_CODE)
        begin
          upin_reg <= moc_pkg::PIN_RST;
          rec_used_reg <= 1'b1;
          unlocked_reg <= 1'b1;
        end
        else
          unlocked_reg <= (pwdata[15:0] == upin_reg);
      end
      else if (wr && paddr == moc_pkg::A_UPIN && (unlocked_reg || upin_reg == 16'h0000))
        upin_reg <= pwdata[15:0];
    end
  end

  // pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_sync_reg <= 2'h0;
      esc_sync_reg <= 2'h0;
      btn_prev_reg <= 1'b0;
      esc_prev_reg <= 1'b0;
    end
    else
    begin
      btn_sync_reg <= {btn_sync_reg[0], button_any};
      esc_sync_reg <= {esc_sync_reg[0], button_esc};
      btn_prev_reg <= btn_sync_reg[1];
      esc_prev_reg <= esc_sync_reg[1];
    end
  end
  assign press = btn_sync_reg[1] & ~btn_prev_reg;
  assign esc_press = esc_sync_reg[1] & ~esc_prev_reg;

  // tenth-second and second ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tenth_cnt_reg <= 32'h00000000;
      sec_cnt_reg <= 32'h00000000;
    end
    else
    begin
      tenth_cnt_reg <= tick_tenth ? 32'h00000000 : tenth_cnt_reg + 32'h00000001;
      sec_cnt_reg <= (tick_sec || bus_frame) ? 32'h00000000 : sec_cnt_reg + 32'h00000001;
    end
  end
  assign tick_tenth = (tenth_cnt_reg == 32'(TENTH_CYC - 1));
  assign tick_sec = (sec_cnt_reg == 32'(SEC_CYC - 1));

  // bus frame gap in whole seconds, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_reg <= 8'h00;
    else if (bus_frame)
      gap_reg <= 8'h00;
    else if (tick_sec && gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  end
  assign timed_out = (bto_reg != 8'h00) && (gap_reg >= bto_reg);
  assign crit_meas = meas_over;

  // smoothing: first-order average, shift grows with level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= 24'h000000;
      live_reg <= 16'h0000;
      upd1_reg <= 1'b0;
      upd2_reg <= 1'b0;
    end
    else
    begin
      upd1_reg <= meas_valid;
      upd2_reg <= upd1_reg;
      if (meas_valid)
        acc_reg <= acc_reg + (($signed({meas_value, 8'h00}) - acc_reg) >>>
                   ctrl_reg[moc_pkg::F_SMTH +: 3]);
      if (upd1_reg)
        live_reg <= acc_reg[23:8] + 16'(offs_reg);
    end
  end

  // peak or drop detector with keep timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_reg <= 16'h0000;
      capt_reg <= 16'h0000;
      held_reg <= 1'b0;
      tracking_reg <= 1'b0;
      hold_cnt_reg <= 8'h00;
      upd3_reg <= 1'b0;
    end
    else
    begin
      upd3_reg <= upd2_reg;
      if (esc_press)
        held_reg <= 1'b0;
      else if (tick_tenth && held_reg && keep_reg != 8'h00)
      begin
        hold_cnt_reg <= hold_cnt_reg - 8'h01;
        if (hold_cnt_reg <= 8'h01)
          held_reg <= 1'b0;
      end
      if (upd2_reg)
      begin
        if (!tracking_reg || (ctrl_reg[moc_pkg::F_INV] ? live_reg < ext_reg
                                                       : live_reg > ext_reg))
        begin
          ext_reg <= live_reg;
          tracking_reg <= 1'b1;
        end
        else if ((ctrl_reg[moc_pkg::F_INV] ? live_reg - ext_reg : ext_reg - live_reg)
                 >= swing_reg)
        begin
          capt_reg <= ext_reg;
          held_reg <= 1'b1; // capture wins over an escape in the same cycle
          hold_cnt_reg <= keep_reg;
          ext_reg <= live_reg;
        end
      end
    end
  end

  // zero keep time in live display means the peak never lingers
  assign peak_val = (held_reg && (keep_reg != 8'h00 || ctrl_reg[moc_pkg::F_DSRC]))
                    ? capt_reg : live_reg;
  assign out_src_val = ctrl_reg[moc_pkg::F_OSRC] ? peak_val : live_reg;

  // value routing to display, relays and edit permissions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      display_value <= 16'h0000;
      relay_value <= 64'h0;
      relay_edit_ok <= 4'h0;
    end
    else
    begin
      display_value <= ctrl_reg[moc_pkg::F_DSRC] ? peak_val : live_reg;
      for (int i = 0; i < 4; i++)
      begin
        relay_value[16*i +: 16] <= ctrl_reg[moc_pkg::F_RSRC + i] ? peak_val : live_reg;
        relay_edit_ok[i] <= ctrl_reg[moc_pkg::F_UNLK + i] | unlocked_reg |
                            (upin_reg == 16'h0000);
      end
    end
  end

  // beeper: set beats a press in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      beeper <= 1'b0;
      relay_prev_reg <= 4'h0;
      crit_prev_reg <= 1'b0;
      critical <= 1'b0;
    end
    else
    begin
      relay_prev_reg <= relay_active;
      crit_prev_reg <= crit_meas | timed_out;
      critical <= (mode == moc_pkg::OM_BUS) ? timed_out : crit_meas;
      if ((ctrl_reg[moc_pkg::F_FBEEP] && (crit_meas | timed_out) && !crit_prev_reg) ||
          |(relay_active & ~relay_prev_reg & ctrl_reg[moc_pkg::F_RBEEP +: 4]))
        beeper <= 1'b1;
      else if (press)
        beeper <= 1'b0;
    end
  end

  // scaling: numerator |W-low|*span, divided serially by |high-low|
  assign diff_w = 17'(out_src_val) - 17'(low_reg);
  assign diff_h = 17'(high_reg) - 17'(low_reg);
  assign span = (mode == moc_pkg::OM_0_20) ? moc_pkg::I_20MA : moc_pkg::I_16MA;
  assign trial = {rem_reg, quo_reg[31]} - {1'b0, den_reg};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= S_IDLE;
      quo_reg <= 32'h00000000;
      rem_reg <= 32'h00000000;
      den_reg <= 32'h00000000;
      neg_reg <= 1'b0;
      step_reg <= 6'h00;
      w_reg <= 16'h0000;
    end
    else
    begin
      case (st_reg)
        S_IDLE:
          if (upd3_reg)
          begin
            w_reg <= out_src_val;
            quo_reg <= 32'(diff_w[16] ? -diff_w : diff_w) * 32'(span);
            den_reg <= 32'(diff_h[16] ? -diff_h : diff_h);
            neg_reg <= diff_w[16] ^ diff_h[16];
            rem_reg <= 32'h00000000;
            step_reg <= 6'h00;
            st_reg <= S_DIV;
          end
        S_DIV:
        begin
          if (!trial[32])
          begin
            rem_reg <= trial[31:0];
            quo_reg <= {quo_reg[30:0], 1'b1};
          end
          else
          begin
            rem_reg <= {rem_reg[30:0], quo_reg[31]};
            quo_reg <= {quo_reg[30:0], 1'b0};
          end
          step_reg <= step_reg + 6'h01;
          if (step_reg == 6'h1F)
            st_reg <= S_DONE;
        end
        S_DONE: st_reg <= S_IDLE;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // clamp limits from the extension settings
  assign lo_prod = 21'(moc_pkg::I_4MA) * 21'(loext_reg);
  assign hi_prod = 21'(moc_pkg::I_20MA) * 21'(hiext_reg);
  assign imin = (mode == moc_pkg::OM_0_20) ? 13'h0000
                : moc_pkg::I_4MA - 13'(lo_prod / 21'(moc_pkg::PERMILLE));
  assign imax = moc_pkg::I_20MA + 13'(hi_prod / 21'(moc_pkg::PERMILLE));
  assign q_sat = (|quo_reg[31:14]) ? 14'h3FFF : quo_reg[13:0];
  assign raw_i = (mode == moc_pkg::OM_0_20 ? 16'h0000 : 16'(moc_pkg::I_4MA)) +
                 (neg_reg ? -16'(q_sat) : 16'(q_sat));

  // computed value latched at the end of each division
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      calc_reg <= 13'h0000;
    else if (st_reg == S_DONE)
    begin
      if (raw_i < $signed({3'h0, imin}))
        calc_reg <= imin;
      else if (raw_i > $signed({3'h0, imax}))
        calc_reg <= imax;
      else
        calc_reg <= raw_i[12:0];
    end
  end

  // loop output: mode, fault override, then bus setpoint or computed value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_setpoint <= 13'h0000;
      loop_enable <= 1'b0;
    end
    else
    begin
      loop_enable <= (mode != moc_pkg::OM_OFF);
      if (mode == moc_pkg::OM_OFF)
        loop_setpoint <= 13'h0000;
      else if (critical)
      begin
        case (fovr)
          moc_pkg::FO_22P1: loop_setpoint <= moc_pkg::I_22P1;
          moc_pkg::FO_3P4: loop_setpoint <= moc_pkg::I_3P4;
          moc_pkg::FO_ZERO: loop_setpoint <= 13'h0000;
          default: loop_setpoint <= loop_setpoint;
        endcase
      end
      else if (mode == moc_pkg::OM_BUS)
        loop_setpoint <= bussp_reg;
      else
        loop_setpoint <= calc_reg;
    end
  end
endmodule

// file: tb/moc_top_sva.sv
// port assertions for the meter output control block
`timescale 1ns/100ps
module moc_top_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // panel, relays and loop
  input wire logic button_any,
  input wire logic [3:0] relay_active,
  input wire logic [12:0] loop_setpoint,
  input wire logic beeper,
  input wire logic critical
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // one wait-free access follows each setup
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_access_a: assert property (pready |-> psel && penable && !$past(pready))
    else $error("pready outside a single access");
  unmapped_err_a: assert property (pready && paddr > 8'h2C |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (pready && paddr <= 8'h2C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  // read data only moves after a read setup
  prdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  reset_clear_a: assert property ($rose(presetn) |-> loop_setpoint == 13'h0000 && !beeper)
    else $error("outputs not cleared by reset");
  setpoint_max_a: assert property (loop_setpoint <= 13'h1800)
    else $error("setpoint above 24 mA");
  // synchroniser costs three edges, one spare allowed
  beep_silence_a: assert property (($rose(button_any) && !critical) ##1
    ($stable(relay_active) && !critical)[*4] |-> !beeper)
    else $error("beeper not silenced by button");
  beep_c: cover property ($rose(beeper));
  crit_c: cover property ($rose(critical));
  err_c: cover property (pready && pslverr);
endmodule

bind moc_top moc_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .button_any, .relay_active, .loop_setpoint, .beeper, .critical);

// file: tb/moc_partner.sv
// current loop receiver and front-panel operator model
`timescale 1ns/100ps
module moc_partner (
  // clock
  input wire logic pclk,
  // current loop from the block
  input wire logic [12:0] loop_setpoint,
  input wire logic loop_enable,
  // panel pins to the block
  output logic button_any,
  output logic button_esc
);
  logic [12:0] loop_reading;
  // receiver sees no current while the loop is disabled
  always_ff @(posedge pclk)
    loop_reading <= loop_enable ? loop_setpoint : 13'h0000;
  // buttons idle at time zero
  initial
  begin
    button_any = 1'b0;
    button_esc = 1'b0;
  end
  // held well past the two-flop synchroniser so a press is never lost
  task automatic press();
    @(posedge pclk);
    button_any <= 1'b1;
    repeat (6) @(posedge pclk);
    button_any <= 1'b0;
  endtask
  task automatic esc();
    @(posedge pclk);
    button_esc <= 1'b1;
    repeat (6) @(posedge pclk);
    button_esc <= 1'b0;
  endtask
endmodule

// file: tb/moc_top_tb.sv
// self-checking bench for the meter output control block
`timescale 1ns/100ps
module moc_top_tb;
  localparam logic [15:0] RCODE = 16'h5A3C; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, meas_valid, meas_over, bus_frame;
  logic button_any, button_esc, pready, pslverr, loop_enable, beeper, critical, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] meas_value, display_value;
  logic [3:0] relay_active, relay_edit_ok;
  logic [12:0] loop_setpoint;
  logic [63:0] relay_value;
  logic [12:0] fexp [4];
  int mismatches, checked, cycles;
  moc_top #(.TENTH_CYC(10), .SEC_CYC(50), .RECOVERY_CODE(RCODE)) u_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_valid,
    .meas_value, .meas_over, .relay_active, .bus_frame, .button_any, .button_esc,
    .loop_setpoint, .loop_enable, .beeper, .critical, .display_value, .relay_value,
    .relay_edit_ok);
  moc_partner u_partner (.pclk, .loop_setpoint, .loop_enable, .button_any, .button_esc);
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // hang guard, well above the roughly 1700 cycles the run needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until pready is seen high at a rising edge, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 20)
      mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // spacing keeps the divider free for every update
  task automatic meas(input logic signed [15:0] x);
    @(posedge pclk);
    meas_valid <= 1'b1;
    meas_value <= x;
    @(posedge pclk);
    meas_valid <= 1'b0;
    repeat (45) @(posedge pclk);
  endtask
  task automatic point(input logic [31:0] c, input logic [15:0] lo, input logic [15:0] hi,
    input logic signed [15:0] x, input logic [12:0] exp);
    apb(1'b1, moc_pkg::A_CTRL, c);
    apb(1'b1, moc_pkg::A_LOW, {16'h0000, lo});
    apb(1'b1, moc_pkg::A_HIGH, {16'h0000, hi});
    meas(x);
    cmp("loop", {19'h00000, exp}, {19'h00000, u_partner.loop_reading});
  endtask
  task automatic t_reset();
    apb(1'b0, moc_pkg::A_HIGH, 32'h00000000);
    cmp("high", 32'h00000064, rd);
    apb(1'b0, moc_pkg::A_SWING, 32'h00000000);
    cmp("swing", 32'h0000000A, rd);
    apb(1'b1, moc_pkg::A_LIVE, 32'h00000055);
    apb(1'b0, moc_pkg::A_LIVE, 32'h00000000);
    cmp("live", 32'h00000000, rd);
    apb(1'b0, 8'h30, 32'h00000000);
    cmp("err", 32'h00000001, {31'h00000000, err});
    cmp("edit", 32'h0000000F, {28'h0000000, relay_edit_ok});
  endtask
  task automatic t_scale();
    point(32'h1, 16'h0000, 16'h0064, 16'sd50, 13'h0A00);
    point(32'h2, 16'h0000, 16'h0064, 16'sd25, 13'h0800);
    point(32'h2, 16'h0064, 16'h0000, 16'sd25, 13'h1000);
    point(32'h0, 16'h0000, 16'h0064, 16'sd50, 13'h0000);
    apb(1'b1, moc_pkg::A_BUSSP, 32'h00000ABC);
    point(32'h3, 16'h0000, 16'h0064, 16'sd50, 13'h0ABC);
  endtask
  task automatic t_clamp();
    point(32'h1, 16'h0000, 16'h0064, 16'sd150, 13'h1400);
    point(32'h2, 16'h0000, 16'h0064, -16'sd50, 13'h0400);
    apb(1'b1, moc_pkg::A_CLAMP, 32'h006401F4);
    point(32'h2, 16'h0000, 16'h0064, 16'sd150, 13'h1600);
    point(32'h2, 16'h0000, 16'h0064, -16'sd50, 13'h0200);
    apb(1'b1, moc_pkg::A_CLAMP, 32'h00000000);
  endtask
  task automatic t_offset();
    apb(1'b1, moc_pkg::A_OFFS, 32'h0000000A);
    point(32'h1, 16'h0000, 16'h0064, 16'sd40, 13'h0A00);
    cmp("display", 32'd50, {16'h0000, display_value});
    cmp("relay", 32'd50, {16'h0000, relay_value[15:0]});
    apb(1'b1, moc_pkg::A_OFFS, 32'h0000007F);
    meas(16'sd1);
    apb(1'b0, moc_pkg::A_LIVE, 32'h00000000);
    cmp("live", 32'd100, {16'h0000, rd[15:0]});
    apb(1'b1, moc_pkg::A_OFFS, 32'h00000000);
  endtask
  task automatic t_fault();
    fexp = '{13'h0800, moc_pkg::I_22P1, moc_pkg::I_3P4, 13'h0000};
    for (int f = 0; f < 4; f++)
    begin
      point(32'h6 | (f << 14), 16'h0000, 16'h0064, 16'sd25, 13'h0800);
      meas_over <= 1'b1;
      meas(16'sd25);
      cmp("fault", {19'h00000, fexp[f]}, {19'h00000, loop_setpoint});
      cmp("critical", 32'h1, {31'h00000000, critical});
      cmp("beep", 32'h1, {31'h00000000, beeper});
      u_partner.press();
      repeat (4) @(posedge pclk);
      cmp("silent", 32'h0, {31'h00000000, beeper});
      meas_over <= 1'b0;
      meas(16'sd25);
      cmp("back", 32'h00000800, {19'h00000, loop_setpoint});
    end
    apb(1'b1, moc_pkg::A_CTRL, 32'h00000008);
    relay_active <= 4'h2;
    repeat (6) @(posedge pclk);
    cmp("nobeep", 32'h0, {31'h00000000, beeper});
    relay_active <= 4'h3;
    repeat (6) @(posedge pclk);
    cmp("rbeep", 32'h1, {31'h00000000, beeper});
    u_partner.press();
    relay_active <= 4'h0;
  endtask
  task automatic t_peak();
    apb(1'b1, moc_pkg::A_CTRL, 32'h00002102);
    meas(16'sd90);
    meas(16'sd40);
    cmp("peak", 32'd90, {16'h0000, display_value});
    cmp("loop", 32'h00001266, {19'h00000, loop_setpoint});
    cmp("relay_live", 32'd40, {16'h0000, relay_value[15:0]});
    u_partner.esc();
    repeat (4) @(posedge pclk);
    cmp("esc", 32'd40, {16'h0000, display_value});
    meas(16'sd45);
    meas(16'sd40);
    cmp("noswing", 32'd40, {16'h0000, display_value});
    apb(1'b1, moc_pkg::A_CTRL, 32'h00100000);
    meas(16'sd0);
    cmp("smooth", 32'd20, {16'h0000, display_value});
  endtask
  task automatic t_bus();
    apb(1'b1, moc_pkg::A_CTRL, 32'h0000C003);
    apb(1'b1, moc_pkg::A_TIME, 32'h00000100);
    repeat (3) @(posedge pclk);
    cmp("bus_crit", 32'h1, {31'h00000000, critical});
    cmp("bus_fault", 32'h0, {19'h00000, loop_setpoint});
    bus_frame <= 1'b1;
    @(posedge pclk);
    bus_frame <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp("bus_ok", 32'h00000ABC, {19'h00000, loop_setpoint});
    repeat (60) @(posedge pclk);
    cmp("bus_late", 32'h1, {31'h00000000, critical});
    apb(1'b1, moc_pkg::A_TIME, 32'h00000000);
  endtask
  task automatic t_pin();
    apb(1'b1, moc_pkg::A_UPIN, 32'h00001234);
    apb(1'b1, moc_pkg::A_CTRL, 32'h00050000);
    repeat (3) @(posedge pclk);
    cmp("edit", 32'h5, {28'h0000000, relay_edit_ok});
    apb(1'b1, moc_pkg::A_PIN, 32'h00001234);
    apb(1'b0, moc_pkg::A_UPIN, 32'h00000000);
    cmp("pin", 32'h00001234, rd);
    apb(1'b1, moc_pkg::A_PIN, {16'h0000, RCODE});
    apb(1'b0, moc_pkg::A_PIN, 32'h00000000);
    cmp("used", 32'h1, {31'h00000000, rd[1]});
    apb(1'b0, moc_pkg::A_UPIN, 32'h00000000);
    cmp("cleared", 32'h0, rd);
    apb(1'b1, moc_pkg::A_CTRL, 32'h00000000);
    apb(1'b1, moc_pkg::A_UPIN, 32'h00004321);
    apb(1'b1, moc_pkg::A_PIN, 32'h00000000);
    apb(1'b1, moc_pkg::A_PIN, {16'h0000, RCODE});
    repeat (3) @(posedge pclk);
    cmp("once", 32'h0, {28'h0000000, relay_edit_ok});
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, meas_valid, meas_over, bus_frame} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    meas_value = 16'sd0;
    relay_active = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_scale();
    t_clamp();
    t_offset();
    t_fault();
    t_peak();
    t_bus();
    t_pin();
    complete_run();
  end
endmodule
